// ==== ctm_pkg.sv ====
package ctm_pkg;

    // Register selects of the register access port
    typedef enum logic [3:0] {
        SEL_OFFCORE0,
        SEL_OFFCORE1,
        SEL_METRICS,
        SEL_CAPABILITY,
        SEL_GLOBAL_CTRL,
        SEL_GLOBAL_FLAGS,
        SEL_FLAG_SETTER,
        SEL_FLAG_CLEARER,
        SEL_SLOTS_CTR,
        SEL_UNUSED
    } ctm_sel_t;

    // Widths
    localparam int DATA_W      = 64;
    localparam int SLOTS_CTR_W = 48;
    localparam int ACC_W       = 32;
    localparam int NUM_W       = 40;
    localparam int FRAC_W      = 8;
    localparam int NUM_OCR     = 2;
    localparam int SEL_STORE_W = 40;

    // Off-core response select layout
    localparam int OCR_REQ_LSB   = 0;
    localparam int OCR_REQ_MSB   = 15;
    localparam int OCR_ANY_BIT   = 16;
    localparam int OCR_RESP_MSB  = 39;
    localparam logic [63:0] OCR_DRAM_MASK     = 64'h0000_0001_8400_0000;
    localparam logic [63:0] OCR_NON_DRAM_MASK = 64'h0000_0020_0400_0000;
    localparam logic [63:0] OCR_LLC_MISS_MASK = 64'h0000_003F_FFC0_0000;
    localparam logic [63:0] OCR_LLC_HIT_MASK  = 64'h0000_0000_001C_0000;
    localparam int OCR_SNP_NOT_NEEDED = 32;
    localparam int OCR_SNP_MISS       = 33;
    localparam int OCR_SNP_HIT_CLEAN  = 34;
    localparam int OCR_SNP_RSVD_A     = 30;
    localparam int OCR_SNP_RSVD_B     = 35;
    localparam int OCR_SNP_HITM       = 36;

    // Global control, flag and capability bits
    localparam int SLOTS_EN_BIT    = 35;
    localparam int TOPDOWN_EN_BIT  = 48;
    localparam int SLOTS_OVF_BIT   = 35;
    localparam int TOPDOWN_OVF_BIT = 48;
    localparam int CAP_METRICS_BIT = 15;

    // Values after reset, fraction scale and divider step count
    localparam logic [63:0] CTRL_RESET  = 64'h0;
    localparam logic [63:0] OCR_RESET   = 64'h0;
    localparam logic [7:0]  FRAC_RESET  = 8'h00;
    localparam logic [7:0]  FRAC_SCALE  = 8'hFF;
    localparam int          DIV_STEPS   = 8;

    // Transaction seen by the off-core response qualifier
    typedef struct packed {
        logic [15:0] req_type;
        logic        dram;
        logic        non_dram;
        logic        llc_miss;
        logic        llc_hit;
        logic        snp_not_needed;
        logic        snp_miss;
        logic        snp_hit_clean;
        logic        snp_hitm;
    } ctm_txn_t;

    // Issue slots attributed in one cycle
    typedef struct packed {
        logic [2:0] retiring;
        logic [2:0] bad_spec;
        logic [2:0] frontend;
        logic [2:0] backend;
    } ctm_slots_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        ctm_sel_t    sel;
        logic [63:0] wdata;
    } ctm_req_t;

endpackage : ctm_pkg

// ==== ctm_frac_div.sv ====
`timescale 1ns/1ps
module ctm_frac_div (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Request
    input  wire logic        start_i,
    input  wire logic [39:0] num_i,
    input  wire logic [31:0] den_i,
    // Answer
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       quot_o
);

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [3:0]  step;
        logic [39:0] rem;
        logic [31:0] den;
        logic [7:0]  quot;
    } ctm_div_st_t;

    ctm_div_st_t st_reg;
    ctm_div_st_t st_next;

    // One quotient bit per cycle, most significant first
    always_comb begin
        logic [39:0] trial;
        trial   = 40'h0;
        st_next = st_reg;
        st_next.done = 1'b0;
        if (!st_reg.busy) begin
            if (start_i) begin
                st_next.busy = 1'b1;
                st_next.step = 4'(ctm_pkg::DIV_STEPS - 1);
                st_next.rem  = num_i;
                st_next.den  = den_i;
                st_next.quot = ctm_pkg::FRAC_RESET;
            end
        end else begin
            trial = 40'({8'h00, st_reg.den} << st_reg.step);
            if (st_reg.den != 32'h0 && st_reg.rem >= trial) begin
                st_next.rem = st_reg.rem - trial;
                st_next.quot[st_reg.step[2:0]] = 1'b1;
            end
            if (st_reg.step == 4'h0) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.step = st_reg.step - 4'h1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o = st_reg.busy;
    assign done_o = st_reg.done;
    assign quot_o = st_reg.quot;

endmodule : ctm_frac_div

// ==== ctm_core_monitor.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1: A combined response category counts only when all its select bits are one.
// RULE2: Software must choose any, a combined category, or supplier with snoop bits.
// RULE3: With the any bit set, response bits 17 to 39 are ignored.
// RULE4: Main memory supply counts when bits 26, 31 and 32 are set.
// RULE5: Other system supply, including MMIO, counts when bits 26 and 37 set.
// RULE6: Last-level cache miss counts when bits 22 through 37 are all set.
// RULE7: Last-level cache hit counts when bits 18, 19 and 20 are set.
// RULE8: Bit 32 selects requests that needed no snoop.
// RULE9: Bit 33 selects requests whose snoop missed every cache.
// RULE10: Bit 34 selects clean snoop hits not forwarded back.
// RULE11: Bit 36 selects modified snoop hits forwarded; bits 30 and 35 reserved.
// RULE12: Metrics register low half holds four 8-bit fractions of 255.
// RULE13: Capability bit 15 reports that the metrics feature exists.
// RULE14: Metrics run only with control bit 48 and slots counter enable set.
// RULE15: Writing one to setter bit 48 sets the metrics overflow flag.
// RULE16: Writing one to clearer bit 48 clears the metrics overflow flag.
// RULE17: Metrics overflow sets flag bit 48 and raises the monitor interrupt.
// RULE18: Metrics are derived from slots counter, both advance together.
// RULE19: Software resynchronizes both registers when flag 35 or 48 is set.
// RULE20: Software starts both from zero and clears them periodically.
// RULE21: Software keeps both disabled over save, toggling bits 35, 48 together.
// RULE22: Software restores the slots counter before the metrics register.
module ctm_core_monitor (
    // Clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    // Register access port
    input  wire ctm_pkg::ctm_req_t   reg_req_i,
    output logic                     reg_rd_valid_o,
    output logic [63:0]              reg_rdata_o,
    // Off-core transactions
    input  wire logic                txn_valid_i,
    input  wire ctm_pkg::ctm_txn_t   txn_i,
    output logic [1:0]               ocr_count_o,
    // Slot attribution
    input  wire ctm_pkg::ctm_slots_t slots_i,
    // Interrupt
    output logic                     perf_monitor_interrupt_o
);

    typedef struct packed {
        logic [1:0][39:0] ocr_sel;
        logic [63:0]      ctrl;
        logic             slots_ovf;
        logic             topdown_ovf;
        logic [47:0]      slots_ctr;
        logic [3:0][31:0] acc;
        logic [31:0]      acc_total;
        logic [3:0][7:0]  frac;
        logic [1:0]       div_idx;
        logic             div_pend;
        logic             rd_valid;
        logic [63:0]      rdata;
        logic [1:0]       ocr_count;
        logic             perf_monitor_interrupt;
    } ctm_st_t;

    ctm_st_t st_reg;
    ctm_st_t st_next;

    logic        div_start;
    logic [39:0] div_num;
    logic        div_busy;
    logic        div_done;
    logic [7:0]  div_quot;

    // Off-core response qualification of one transaction
    function automatic logic ctm_ocr_match(input logic [39:0] sel,
                                           input ctm_pkg::ctm_txn_t t);
        logic [63:0] s;
        logic        req_ok;
        logic        sup_ok;
        logic        snp_sel;
        logic        snp_ok;
        s       = {24'h0, sel};
        req_ok  = |(sel[ctm_pkg::OCR_REQ_MSB:ctm_pkg::OCR_REQ_LSB] & t.req_type);
        sup_ok  = 1'b0;
        snp_sel = 1'b0;
        snp_ok  = 1'b0;
        // Combined categories need every bit of their mask
        if ((s & ctm_pkg::OCR_DRAM_MASK) == ctm_pkg::OCR_DRAM_MASK && t.dram) begin
            sup_ok = 1'b1; // see RULE1 see RULE4
        end
        if ((s & ctm_pkg::OCR_NON_DRAM_MASK) == ctm_pkg::OCR_NON_DRAM_MASK
            && t.non_dram) begin
            sup_ok = 1'b1; // see RULE5
        end
        if ((s & ctm_pkg::OCR_LLC_MISS_MASK) == ctm_pkg::OCR_LLC_MISS_MASK
            && t.llc_miss) begin
            sup_ok = 1'b1; // see RULE6
        end
        if ((s & ctm_pkg::OCR_LLC_HIT_MASK) == ctm_pkg::OCR_LLC_HIT_MASK
            && t.llc_hit) begin
            sup_ok = 1'b1; // see RULE7
        end
        // Snoop outcome filter; reserved bits 30 and 35 select nothing
        snp_sel = s[ctm_pkg::OCR_SNP_NOT_NEEDED] | s[ctm_pkg::OCR_SNP_MISS]
                | s[ctm_pkg::OCR_SNP_HIT_CLEAN] | s[ctm_pkg::OCR_SNP_HITM]; // see RULE11
        snp_ok  = (s[ctm_pkg::OCR_SNP_NOT_NEEDED] & t.snp_not_needed) // see RULE8
                | (s[ctm_pkg::OCR_SNP_MISS] & t.snp_miss)              // see RULE9
                | (s[ctm_pkg::OCR_SNP_HIT_CLEAN] & t.snp_hit_clean)    // see RULE10
                | (s[ctm_pkg::OCR_SNP_HITM] & t.snp_hitm);             // see RULE11
        if (sel[ctm_pkg::OCR_ANY_BIT]) begin
            return req_ok; // see RULE3
        end
        return req_ok & sup_ok & (!snp_sel | snp_ok);
    endfunction : ctm_ocr_match

    // Widen a 3-bit slot count
    function automatic logic [31:0] ctm_widen(input logic [2:0] v);
        return {29'h0, v};
    endfunction : ctm_widen

    // Next state
    always_comb begin
        logic        slots_en;
        logic        active;
        logic [31:0] add_total;
        logic [48:0] ctr_sum;
        logic [32:0] tot_sum;
        logic [3:0][31:0] inc;
        logic        slots_wrap;
        logic        topdown_wrap;
        logic        force_td;
        logic        clear_td;
        logic        force_sl;
        logic        clear_sl;
        slots_en     = 1'b0;
        active       = 1'b0;
        add_total    = 32'h0;
        ctr_sum      = 49'h0;
        tot_sum      = 33'h0;
        inc          = '0;
        slots_wrap   = 1'b0;
        topdown_wrap = 1'b0;
        force_td     = 1'b0;
        clear_td     = 1'b0;
        force_sl     = 1'b0;
        clear_sl     = 1'b0;
        st_next      = st_reg;
        st_next.rd_valid  = 1'b0;
        st_next.ocr_count = 2'b00;
        st_next.perf_monitor_interrupt       = 1'b0;

        // Counting gates
        slots_en = st_reg.ctrl[ctm_pkg::SLOTS_EN_BIT];
        active   = slots_en & st_reg.ctrl[ctm_pkg::TOPDOWN_EN_BIT]; // see RULE14

        // Off-core response counting pulses
        for (int i = 0; i < ctm_pkg::NUM_OCR; i++) begin
            st_next.ocr_count[i] = txn_valid_i & ctm_ocr_match(st_reg.ocr_sel[i], txn_i);
        end

        // Slots counter and category accumulators advance in the same cycle
        inc[0]    = ctm_widen(slots_i.retiring);
        inc[1]    = ctm_widen(slots_i.bad_spec);
        inc[2]    = ctm_widen(slots_i.frontend);
        inc[3]    = ctm_widen(slots_i.backend);
        add_total = inc[0] + inc[1] + inc[2] + inc[3];
        if (slots_en) begin
            ctr_sum           = {1'b0, st_reg.slots_ctr} + {17'h0, add_total};
            st_next.slots_ctr = ctr_sum[47:0];
            slots_wrap        = ctr_sum[48];
        end
        if (active) begin
            tot_sum           = {1'b0, st_reg.acc_total} + {1'b0, add_total};
            topdown_wrap      = tot_sum[32]; // see RULE17
            st_next.acc_total = tot_sum[31:0]; // see RULE18
            for (int i = 0; i < 4; i++) begin
                st_next.acc[i] = st_reg.acc[i] + inc[i];
            end
        end

        // Fraction refresh, one category per divide
        if (active && !div_busy && !st_reg.div_pend) begin
            st_next.div_pend = 1'b1;
        end
        if (div_done) begin
            st_next.frac[st_reg.div_idx] = div_quot; // see RULE12
            st_next.div_idx  = st_reg.div_idx + 2'b01;
            st_next.div_pend = 1'b0;
        end

        // Register writes
        if (reg_req_i.wr) begin
            case (reg_req_i.sel)
                ctm_pkg::SEL_OFFCORE0: begin
                    st_next.ocr_sel[0] = reg_req_i.wdata[39:0];
                end
                ctm_pkg::SEL_OFFCORE1: begin
                    st_next.ocr_sel[1] = reg_req_i.wdata[39:0];
                end
                ctm_pkg::SEL_METRICS: begin
                    // Restart the derivation from the written fractions
                    st_next.frac      = reg_req_i.wdata[31:0];
                    st_next.acc       = '0;
                    st_next.acc_total = 32'h0;
                    topdown_wrap      = 1'b0;
                end
                ctm_pkg::SEL_GLOBAL_CTRL: begin
                    st_next.ctrl = reg_req_i.wdata;
                end
                ctm_pkg::SEL_FLAG_SETTER: begin
                    force_td = reg_req_i.wdata[ctm_pkg::TOPDOWN_OVF_BIT]; // see RULE15
                    force_sl = reg_req_i.wdata[ctm_pkg::SLOTS_OVF_BIT];
                end
                ctm_pkg::SEL_FLAG_CLEARER: begin
                    clear_td = reg_req_i.wdata[ctm_pkg::TOPDOWN_OVF_BIT]; // see RULE16
                    clear_sl = reg_req_i.wdata[ctm_pkg::SLOTS_OVF_BIT];
                end
                ctm_pkg::SEL_SLOTS_CTR: begin
                    st_next.slots_ctr = reg_req_i.wdata[47:0];
                    slots_wrap        = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Overflow flags, a hardware set wins over a clear
        if (clear_td) begin
            st_next.topdown_ovf = 1'b0; // see RULE16
        end
        if (topdown_wrap || force_td) begin
            st_next.topdown_ovf = 1'b1; // see RULE15 see RULE17
        end
        if (clear_sl) begin
            st_next.slots_ovf = 1'b0;
        end
        if (slots_wrap || force_sl) begin
            st_next.slots_ovf = 1'b1;
        end
        st_next.perf_monitor_interrupt = topdown_wrap | slots_wrap; // see RULE17

        // Register reads, answered one cycle later
        if (reg_req_i.rd) begin
            st_next.rd_valid = 1'b1;
            st_next.rdata    = 64'h0;
            case (reg_req_i.sel)
                ctm_pkg::SEL_OFFCORE0: begin
                    st_next.rdata = {24'h0, st_reg.ocr_sel[0]};
                end
                ctm_pkg::SEL_OFFCORE1: begin
                    st_next.rdata = {24'h0, st_reg.ocr_sel[1]};
                end
                ctm_pkg::SEL_METRICS: begin
                    st_next.rdata = {32'h0, st_reg.frac}; // see RULE12
                end
                ctm_pkg::SEL_CAPABILITY: begin
                    st_next.rdata[ctm_pkg::CAP_METRICS_BIT] = 1'b1; // see RULE13
                end
                ctm_pkg::SEL_GLOBAL_CTRL: begin
                    st_next.rdata = st_reg.ctrl;
                end
                ctm_pkg::SEL_GLOBAL_FLAGS: begin
                    st_next.rdata[ctm_pkg::SLOTS_OVF_BIT]   = st_reg.slots_ovf;
                    st_next.rdata[ctm_pkg::TOPDOWN_OVF_BIT] = st_reg.topdown_ovf; // see RULE17
                end
                ctm_pkg::SEL_SLOTS_CTR: begin
                    st_next.rdata = {16'h0, st_reg.slots_ctr};
                end
                default: begin
                    st_next.rdata = 64'h0;
                end
            endcase
        end
    end

    // Divider operands: selected category times 255 over total
    assign div_start = st_reg.div_pend & !div_busy & !div_done;
    assign div_num   = 40'(st_reg.acc[st_reg.div_idx]) * 40'(ctm_pkg::FRAC_SCALE);

    // Sequential fraction divider
    ctm_frac_div u_frac_div (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (div_start),
        .num_i     (div_num),
        .den_i     (st_reg.acc_total),
        .busy_o    (div_busy),
        .done_o    (div_done),
        .quot_o    (div_quot)
    );

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign reg_rd_valid_o           = st_reg.rd_valid;
    assign reg_rdata_o              = st_reg.rdata;
    assign ocr_count_o              = st_reg.ocr_count;
    assign perf_monitor_interrupt_o = st_reg.perf_monitor_interrupt;

endmodule : ctm_core_monitor

// ==== ctm_prop_monitor.sv ====
`timescale 1ns/1ps
module ctm_prop_monitor (
    // Clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    // Register port
    input  wire ctm_pkg::ctm_req_t   reg_req_i,
    input  wire logic                reg_rd_valid_o,
    input  wire logic [63:0]         reg_rdata_o,
    // Transactions, slots and interrupt
    input  wire logic                txn_valid_i,
    input  wire ctm_pkg::ctm_txn_t   txn_i,
    input  wire logic [1:0]          ocr_count_o,
    input  wire ctm_pkg::ctm_slots_t slots_i,
    input  wire logic                perf_monitor_interrupt_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [39:0] sel0_q;
    logic [39:0] sel1_q;
    logic        rd_flags;

    // Shadow copies of the two select registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel0_q <= 40'h0;
            sel1_q <= 40'h0;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.sel == ctm_pkg::SEL_OFFCORE0) sel0_q <= reg_req_i.wdata[39:0];
            if (reg_req_i.sel == ctm_pkg::SEL_OFFCORE1) sel1_q <= reg_req_i.wdata[39:0];
        end
    end

    // Read of the flag register
    assign rd_flags = reg_req_i.rd && reg_req_i.sel == ctm_pkg::SEL_GLOBAL_FLAGS;

    a_rd_answer: assert property (reg_req_i.rd |=> reg_rd_valid_o) else $error("read not answered");
    a_rd_cause: assert property (reg_rd_valid_o |-> $past(reg_req_i.rd))
        else $error("read valid without read");
    a_ocr_cause: assert property (ocr_count_o != 2'b00 |-> $past(txn_valid_i))
        else $error("match pulse without transaction");
    a_any_bypass: assert property (txn_valid_i && sel0_q[16]
        && (sel0_q[15:0] & txn_i.req_type) != 16'h0 |=> ocr_count_o[0]) else $error("any missed");
    a_dram_match: assert property (txn_valid_i && txn_i.dram && txn_i.snp_not_needed
        && (sel1_q & 40'h01_8400_0000) == 40'h01_8400_0000
        && (sel1_q[15:0] & txn_i.req_type) != 16'h0 |=> ocr_count_o[1]) else $error("memory missed");
    a_cap_present: assert property (reg_req_i.rd && reg_req_i.sel == ctm_pkg::SEL_CAPABILITY
        |=> reg_rdata_o[15]) else $error("capability bit clear");
    a_metrics_upper: assert property (reg_req_i.rd && reg_req_i.sel == ctm_pkg::SEL_METRICS
        |=> reg_rdata_o[63:32] == 32'h0) else $error("metrics upper half not zero");
    a_flag_set: assert property (reg_req_i.wr && reg_req_i.sel == ctm_pkg::SEL_FLAG_SETTER
        && reg_req_i.wdata[48] ##1 !reg_req_i.wr ##1 rd_flags |=> reg_rdata_o[48])
        else $error("flag not set");
    a_flag_clear: assert property (reg_req_i.wr && reg_req_i.sel == ctm_pkg::SEL_FLAG_CLEARER
        && reg_req_i.wdata[48] ##1 !reg_req_i.wr ##1 rd_flags |=> !reg_rdata_o[48])
        else $error("flag not cleared");
    a_pmi_pulse: assert property (perf_monitor_interrupt_o |=> !perf_monitor_interrupt_o)
        else $error("interrupt longer than one cycle");

    // Main scenarios reached
    c_match: cover property (ocr_count_o == 2'b11);
    c_pmi: cover property (perf_monitor_interrupt_o);
    c_flags: cover property (rd_flags ##1 reg_rdata_o[48]);
endmodule : ctm_prop_monitor

bind ctm_core_monitor ctm_prop_monitor u_prop (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .reg_rd_valid_o(reg_rd_valid_o), .reg_rdata_o(reg_rdata_o), .txn_valid_i(txn_valid_i),
    .txn_i(txn_i), .ocr_count_o(ocr_count_o), .slots_i(slots_i),
    .perf_monitor_interrupt_o(perf_monitor_interrupt_o)
);

// ==== ctm_core_monitor_test.sv ====
`timescale 1ns/1ps
module ctm_core_monitor_test;
    // Table entry: select value, transaction flags, expected match
    localparam logic [72:0] TBL [0:9] = '{
        {64'h0000_0000_001C_0001, 8'h10, 1'b1},
        {64'h0000_0002_000C_0001, 8'h14, 1'b0},
        {64'h0000_0001_8400_0001, 8'h88, 1'b1},
        {64'h0000_0001_8400_0001, 8'h84, 1'b0},
        {64'h0000_0020_0400_0001, 8'h40, 1'b1},
        {64'h0000_0002_001C_0001, 8'h14, 1'b1},
        {64'h0000_0004_001C_0001, 8'h11, 1'b0},
        {64'h0000_0004_001C_0001, 8'h12, 1'b1},
        {64'h0000_0010_001C_0001, 8'h11, 1'b1},
        {64'h0000_003F_FFC0_0001, 8'h24, 1'b1}
    };

    logic                clk;
    logic                rst_n;
    ctm_pkg::ctm_req_t   req;
    logic                txn_valid;
    ctm_pkg::ctm_txn_t   txn;
    ctm_pkg::ctm_slots_t slots;
    logic                rd_valid;
    logic [63:0]         rdata;
    logic [1:0]          ocr;
    logic                perf_monitor_interrupt;
    logic                seen_pmi;
    int                  fail_count;
    int                  checks_done;

    // Device under test
    ctm_core_monitor uut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req), .reg_rd_valid_o(rd_valid),
        .reg_rdata_o(rdata), .txn_valid_i(txn_valid), .txn_i(txn), .ocr_count_o(ocr),
        .slots_i(slots), .perf_monitor_interrupt_o(perf_monitor_interrupt)
    );

    // Clock
    always #20 clk = ~clk;

    task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input ctm_pkg::ctm_sel_t s, input logic [63:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, s, d};
        @(posedge clk);
        req <= '0;
    endtask : wr_reg

    task automatic rd_chk(input ctm_pkg::ctm_sel_t s, input logic [63:0] e,
                          input logic [63:0] m = 64'hFFFF_FFFF_FFFF_FFFF);
        @(posedge clk);
        req <= {1'b0, 1'b1, s, 64'h0};
        @(posedge clk);
        req <= '0;
        #1;
        check("read valid", {63'h0, rd_valid}, 64'h1);
        check(s.name(), rdata & m, e);
    endtask : rd_chk

    task automatic txn_chk(input logic [7:0] f, input logic [1:0] e);
        @(posedge clk);
        txn_valid <= 1'b1;
        txn <= {16'h0001, f};
        @(posedge clk);
        txn_valid <= 1'b0;
        #1;
        check("match pulse", {62'h0, ocr}, {62'h0, e});
    endtask : txn_chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req = '0;
        txn_valid = 1'b0;
        txn = '0;
        slots = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(ctm_pkg::SEL_CAPABILITY, 64'h0);
        rd_chk(ctm_pkg::SEL_CAPABILITY, 64'h8000, 64'h8000);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0);
        rd_chk(ctm_pkg::SEL_UNUSED, 64'h0);
        wr_reg(ctm_pkg::SEL_OFFCORE0, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_chk(ctm_pkg::SEL_OFFCORE0, 64'h0000_00FF_FFFF_FFFF);
        // Select 0 has the any bit plus every other bit, so it always matches
        for (int i = 0; i < 10; i++) begin
            wr_reg(ctm_pkg::SEL_OFFCORE1, TBL[i][72:9]);
            txn_chk(TBL[i][8:1], {TBL[i][0], 1'b1});
        end
        // Metrics enable alone must not count
        wr_reg(ctm_pkg::SEL_SLOTS_CTR, 64'h0);
        wr_reg(ctm_pkg::SEL_METRICS, 64'h0);
        wr_reg(ctm_pkg::SEL_GLOBAL_CTRL, 64'h0001_0000_0000_0000);
        slots <= {3'd7, 9'h0};
        repeat (10) @(posedge clk);
        slots <= '0;
        rd_chk(ctm_pkg::SEL_SLOTS_CTR, 64'h0);
        rd_chk(ctm_pkg::SEL_METRICS, 64'h0);
        // Both enables: 20 cycles of 4, 0, 2, 2 slots
        wr_reg(ctm_pkg::SEL_GLOBAL_CTRL, 64'h0001_0008_0000_0000);
        slots <= {3'd4, 3'd0, 3'd2, 3'd2};
        repeat (20) @(posedge clk);
        slots <= '0;
        repeat (100) @(posedge clk);
        rd_chk(ctm_pkg::SEL_SLOTS_CTR, 64'hA0);
        rd_chk(ctm_pkg::SEL_METRICS, 64'h3F3F_007F);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0);
        wr_reg(ctm_pkg::SEL_FLAG_SETTER, 64'h0001_0000_0000_0000);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0001_0000_0000_0000);
        rd_chk(ctm_pkg::SEL_FLAG_SETTER, 64'h0);
        wr_reg(ctm_pkg::SEL_FLAG_CLEARER, 64'h0001_0000_0000_0000);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0);
        // Slots counter wrap raises the flag and the interrupt
        wr_reg(ctm_pkg::SEL_GLOBAL_CTRL, 64'h0000_0008_0000_0000);
        wr_reg(ctm_pkg::SEL_SLOTS_CTR, 64'h0000_FFFF_FFFF_FFFC);
        slots <= {3'd4, 9'h0};
        @(posedge clk);
        slots <= '0;
        seen_pmi = 1'b0;
        // The pulse starts at this edge, so look before the next one
        repeat (6) begin
            #1;
            if (perf_monitor_interrupt === 1'b1) seen_pmi = 1'b1;
            @(posedge clk);
        end
        check("interrupt", {63'h0, seen_pmi}, 64'h1);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0000_0008_0000_0000);
        rd_chk(ctm_pkg::SEL_SLOTS_CTR, 64'h0);
        // Resynchronise counter and metrics, then drop the wrap flag
        wr_reg(ctm_pkg::SEL_SLOTS_CTR, 64'h0);
        wr_reg(ctm_pkg::SEL_METRICS, 64'h0);
        wr_reg(ctm_pkg::SEL_FLAG_CLEARER, 64'h0000_0008_0000_0000);
        rd_chk(ctm_pkg::SEL_GLOBAL_FLAGS, 64'h0);
        report_and_stop();
    end
endmodule : ctm_core_monitor_test
